//--- include/ecr_pkg.sv
// shared constants, register map and helpers for the ccs timeslot router
`default_nettype none
package ecr_pkg;
    // apb register byte offsets
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_ROUTE  = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;

    // ctrl register fields
    localparam int CTRL_MODE_BIT = 0;   // signaling_mode_select
    localparam int CTRL_RATE_BIT = 1;   // 1 = 8.192 Mbit/s backplane
    localparam int CTRL_FR_LSB   = 2;   // framer number, two bits
    localparam int CTRL_FR_MSB   = 3;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

    // route register fields: enables and channel selects
    localparam int ROUTE_EN_LSB  = 0;   // three side route enables
    localparam int SEL0_LSB      = 8;   // slot 15 channel select
    localparam int SEL1_LSB      = 16;  // slot 16 channel select
    localparam int SEL2_LSB      = 24;  // slot 31 channel select
    localparam int SEL_W         = 5;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
    localparam logic [31:0] ROUTE_MASK  = 32'h1F1F_1F07;
    localparam logic [31:0] CTRL_MASK   = 32'h0000_000F;

    // line timeslots that carry common channel signaling
    localparam int          NSLOT   = 3;
    localparam logic [4:0]  SLOT_A  = 5'h0F;
    localparam logic [4:0]  SLOT_B  = 5'h10;
    localparam logic [4:0]  SLOT_C  = 5'h1F;
    localparam int          CHAN_W  = 7;    // backplane channel index width
    localparam int          BYTE_W  = 8;
    localparam logic [7:0]  BYTE_IDLE = 8'h00;

    // two-entry transmit buffer: ccs flag, slot, byte
    localparam int          BUF_W     = 1 + 5 + BYTE_W;
    localparam int          BUF_DEPTH = 2;
    localparam logic [1:0]  CNT_FULL  = 2'h2;
    localparam logic [1:0]  CNT_EMPTY = 2'h0;
    localparam logic [1:0]  CNT_ONE   = 2'h1;

    // backplane channel for timeslot t: m*t+n, m=1/n=0 or m=4/n=framer
    function automatic logic [6:0] chan_of(input logic [4:0] t,
                                           input logic       rate8,
                                           input logic [1:0] fr);
        logic [6:0] c;
        c = rate8 ? {t, fr} : {2'h0, t};
        return c;
    endfunction
endpackage
`default_nettype wire

//--- core/ecr_router.sv
// ccs timeslot router with apb registers and two-entry transmit buffer
// Overview of operation
// - ccs routing only while mode select set
// - fill slots 15, 16, 31 every frame
// - route off: slot from data input stream
// - route on: slot from control input stream
// - three route enables are independent
// - 5-bit select picks control input channel
// - b7..b0 map to line bits 1..8
// - 2.048 rate: channel equals timeslot
// - 8.192 rate: channel is 4t plus framer
// - received ccs slots always to data output
// - route off: no copy to control output
// - route on: copy to control output too
// - same selects choose control output channel
// - mode select clear means cas mode
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ecr_router
(
    input  wire logic        pclk,              // 250 MHz bus and core clock
    input  wire logic        presetn,           // async reset, active low
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb access phase
    input  wire logic        pwrite,            // apb direction
    input  wire logic [11:0] paddr,             // apb byte address
    input  wire logic [31:0] pwdata,            // apb write data
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error, unmapped
    input  wire logic        bp_in_valid,       // backplane channel strobe
    input  wire logic [6:0]  bp_in_chan,        // backplane channel index
    input  wire logic [7:0]  data_stream_in,    // data input stream byte
    input  wire logic [7:0]  control_stream_in, // control input stream byte
    input  wire logic        line_tx_req,       // framer asks for a slot
    input  wire logic [4:0]  line_tx_req_slot,  // requested line timeslot
    output logic             line_tx_req_ready, // buffer can take request
    output logic             line_tx_valid,     // transmit byte available
    input  wire logic        line_tx_ready,     // framer takes the byte
    output logic [4:0]       line_tx_slot,      // line timeslot of byte
    output logic [7:0]       line_tx_byte,      // byte, bit 7 is line bit 1
    output logic             line_tx_ccs,       // byte filled by this block
    input  wire logic        line_rx_valid,     // received slot strobe
    input  wire logic [4:0]  line_rx_slot,      // received line timeslot
    input  wire logic [7:0]  line_rx_byte,      // received byte
    input  wire logic        bp_out_req,        // backplane output strobe
    input  wire logic [6:0]  bp_out_chan,       // output channel index
    output logic             data_out_en,       // drive data output stream
    output logic [7:0]       data_stream_out,   // data output stream byte
    output logic             control_out_en,    // drive control output
    output logic [7:0]       control_stream_out,// control output byte
    output logic             cas_mode           // mode select clear
);
    // configuration registers
    logic [31:0] ctrl_q;                        // mode, rate, framer
    logic [31:0] route_q;                       // enables and selects
    // apb answer registers
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    // decoded configuration
    wire         ccs_on  = ctrl_q[ecr_pkg::CTRL_MODE_BIT];
    wire         rate8   = ctrl_q[ecr_pkg::CTRL_RATE_BIT];
    wire [1:0]   framer  = ctrl_q[ecr_pkg::CTRL_FR_MSB:ecr_pkg::CTRL_FR_LSB];
    // bus decode
    // acc: first access edge; done: the edge that sees pready high
    wire         acc     = psel & penable & ~pready_q;
    wire         done    = psel & penable & pready_q;
    wire         hit_ctl = (paddr == ecr_pkg::ADDR_CTRL);
    wire         hit_rte = (paddr == ecr_pkg::ADDR_ROUTE);
    wire         hit_sts = (paddr == ecr_pkg::ADDR_STATUS);
    wire         mapped  = hit_ctl | hit_rte | hit_sts;
    wire         wr_ctl  = done & pwrite & hit_ctl;
    wire         wr_rte  = done & pwrite & hit_rte;
    // mode select as it stands after this edge, so that cas_mode never
    // lags the ctrl register by a cycle around a write
    wire         mode_d  = wr_ctl ? pwdata[ecr_pkg::CTRL_MODE_BIT] : ccs_on;

    // per-slot constants and settings
    logic [4:0]  slot_num [ecr_pkg::NSLOT];
    logic [4:0]  slot_sel [ecr_pkg::NSLOT];
    logic [2:0]  side_en;                       // one enable per slot
    // captured bytes per slot
    logic [7:0]  dat_cap_q [ecr_pkg::NSLOT];    // from data input stream
    logic [7:0]  ctl_cap_q [ecr_pkg::NSLOT];    // from control input stream
    logic [7:0]  rx_cap_q  [ecr_pkg::NSLOT];    // from line receive
    logic [7:0]  tx_pick   [ecr_pkg::NSLOT];    // chosen transmit source
    logic [2:0]  tx_hit;                        // requested slot match
    logic [2:0]  rx_hit;                        // received slot match
    logic [2:0]  dout_hit;                      // data output channel match
    logic [2:0]  cout_hit;                      // control output match

    assign slot_num[0] = ecr_pkg::SLOT_A;
    assign slot_num[1] = ecr_pkg::SLOT_B;
    assign slot_num[2] = ecr_pkg::SLOT_C;
    assign slot_sel[0] = route_q[ecr_pkg::SEL0_LSB +: ecr_pkg::SEL_W];
    assign slot_sel[1] = route_q[ecr_pkg::SEL1_LSB +: ecr_pkg::SEL_W];
    assign slot_sel[2] = route_q[ecr_pkg::SEL2_LSB +: ecr_pkg::SEL_W];
    assign side_en = route_q[ecr_pkg::ROUTE_EN_LSB +: ecr_pkg::NSLOT];

    // one set of channel matches and captures per ccs timeslot
    genvar k;
    generate
        for (k = 0; k < ecr_pkg::NSLOT; k = k + 1)
        begin : g_slot
            // channel positions of this slot on the backplane
            wire [6:0] dchan;
            wire [6:0] cchan;
            // 4t plus framer at high rate
            assign dchan = ecr_pkg::chan_of(slot_num[k], rate8, framer);
            assign cchan = ecr_pkg::chan_of(slot_sel[k], rate8, framer);
            assign tx_pick[k]  = side_en[k] ? ctl_cap_q[k] : dat_cap_q[k];
            assign tx_hit[k]   = (line_tx_req_slot == slot_num[k]);
            assign rx_hit[k]   = line_rx_valid & (line_rx_slot == slot_num[k]);
            assign dout_hit[k] = (bp_out_chan == dchan);
            assign cout_hit[k] = side_en[k] & (bp_out_chan == cchan);

            // capture backplane bytes at their channel positions
            // one channel may feed both captures when selects overlap
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    dat_cap_q[k] <= ecr_pkg::BYTE_IDLE;
                    ctl_cap_q[k] <= ecr_pkg::BYTE_IDLE;
                end
                else if (bp_in_valid)
                begin
                    if (bp_in_chan == dchan)
                        dat_cap_q[k] <= data_stream_in;
                    if (bp_in_chan == cchan)
                        ctl_cap_q[k] <= control_stream_in;
                end
            end

            // capture received line bytes of this slot
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    rx_cap_q[k] <= ecr_pkg::BYTE_IDLE;
                else if (rx_hit[k] && ccs_on)
                    rx_cap_q[k] <= line_rx_byte;
            end
        end
    endgenerate

    // transmit selection: lowest matching slot, flag marks ccs fill
    // a request for any other slot still takes a buffer entry
    wire        tx_any  = ccs_on & (|tx_hit);
    wire [7:0]  tx_byte = tx_hit[0] ? tx_pick[0] :
                          tx_hit[1] ? tx_pick[1] :
                          tx_hit[2] ? tx_pick[2] : ecr_pkg::BYTE_IDLE;
    // every request for a ccs slot gets a byte
    // cas mode leaves slot unfilled here
    wire [13:0] push_word = {tx_any, line_tx_req_slot,
                             tx_any ? tx_byte : ecr_pkg::BYTE_IDLE};

    // receive output selection, lowest slot wins on equal selects
    // bytes hold the last capture until the next received frame
    wire        dout_any  = ccs_on & (|dout_hit);
    wire [7:0]  dout_byte = dout_hit[0] ? rx_cap_q[0] :
                            dout_hit[1] ? rx_cap_q[1] : rx_cap_q[2];
    wire        cout_any  = ccs_on & (|cout_hit);
    wire [7:0]  cout_byte = cout_hit[0] ? rx_cap_q[0] :
                            cout_hit[1] ? rx_cap_q[1] : rx_cap_q[2];

    // two-entry shift buffer, entry 0 is the head
    logic [13:0] buf_q [ecr_pkg::BUF_DEPTH];
    logic [1:0]  cnt_q;
    logic        req_rdy_q;
    logic        valid_q;                       // head entry present
    wire         push   = line_tx_req & req_rdy_q;
    wire         pop    = line_tx_valid & line_tx_ready;
    wire [1:0]   cnt_d  = cnt_q + {1'b0, push} - {1'b0, pop};
    // head after a pop comes from entry 1 or a simultaneous push
    wire         pop_one = (cnt_q == ecr_pkg::CNT_ONE);
    wire         head_ld = (cnt_q == ecr_pkg::CNT_EMPTY) |
                           (pop & pop_one);
    wire         tail_ld = push & ((cnt_q == ecr_pkg::CNT_ONE & ~pop) |
                                   (cnt_q == ecr_pkg::CNT_FULL & pop));

    // buffer storage and occupancy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buf_q[0]  <= '0;
            buf_q[1]  <= '0;
            cnt_q     <= ecr_pkg::CNT_EMPTY;
            req_rdy_q <= 1'b1;
        end
        else
        begin
            cnt_q     <= cnt_d;
            req_rdy_q <= (cnt_d != ecr_pkg::CNT_FULL);
            if (pop && !pop_one)
                buf_q[0] <= buf_q[1];
            else if (push && head_ld)
                buf_q[0] <= push_word;
            if (tail_ld)
                buf_q[1] <= push_word;
        end
    end

    // head valid flag from its own flop; follows the next count value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            valid_q <= 1'b0;
        else
            valid_q <= (cnt_d != ecr_pkg::CNT_EMPTY);
    end

    // backplane output registers, one answer per strobe
    // enables pulse for one cycle per strobe on a matching slot channel; bytes follow bp_out_chan every cycle, idle when no slot matches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_out_en        <= 1'b0;
            data_stream_out    <= ecr_pkg::BYTE_IDLE;
            control_out_en     <= 1'b0;
            control_stream_out <= ecr_pkg::BYTE_IDLE;
        end
        else
        begin
            data_out_en        <= bp_out_req & dout_any;
            data_stream_out    <= dout_any ? dout_byte : ecr_pkg::BYTE_IDLE;
            control_out_en     <= bp_out_req & cout_any;
            control_stream_out <= cout_any ? cout_byte : ecr_pkg::BYTE_IDLE;
        end
    end

    // read mux: status shows buffer fill and routing state
    // unmapped reads return zero alongside pslverr
    wire [31:0] status_w = {24'h0, 1'b0, req_rdy_q, cnt_q,
                            1'b0, side_en & {3{ccs_on}}};
    wire [31:0] rd_mux   = hit_ctl ? ctrl_q :
                           hit_rte ? route_q :
                           hit_sts ? status_w : 32'h0000_0000;

    // apb slave: ready one cycle into access, write at completion
    // a write lands only at the edge that completes the access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q    <= ecr_pkg::CTRL_RESET;
            route_q   <= ecr_pkg::ROUTE_RESET;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= acc;
            pslverr_q <= acc & ~mapped;
            prdata_q  <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
            if (wr_ctl)
                ctrl_q <= pwdata & ecr_pkg::CTRL_MASK;
            if (wr_rte)
                route_q <= pwdata & ecr_pkg::ROUTE_MASK;
        end
    end

    // mode flag for the cas path
    // loaded at the same edge as ctrl_q so both always agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cas_mode <= 1'b1;
        else
            cas_mode <= ~mode_d;
    end

    // apb answer comes straight from its flops
    assign prdata            = prdata_q;
    assign pready            = pready_q;
    assign pslverr           = pslverr_q;
    // buffer side outputs: ready flag, valid flag and the head entry
    assign line_tx_req_ready = req_rdy_q;
    assign line_tx_valid     = valid_q;
    // head entry layout: ccs flag on top, then slot, byte at the bottom
    assign line_tx_ccs       = buf_q[0][ecr_pkg::BUF_W-1];
    assign line_tx_slot      = buf_q[0][ecr_pkg::BUF_W-2:ecr_pkg::BYTE_W];
    assign line_tx_byte      = buf_q[0][ecr_pkg::BYTE_W-1:0];
endmodule
`default_nettype wire

//--- verif/ecr_router_props.sv
// port-level assertions for the ccs router
`timescale 1ns/100ps
`default_nettype none
module ecr_router_props
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        line_tx_req,
    input wire logic [4:0]  line_tx_req_slot,
    input wire logic        line_tx_req_ready,
    input wire logic        line_tx_valid,
    input wire logic        line_tx_ready,
    input wire logic [4:0]  line_tx_slot,
    input wire logic [7:0]  line_tx_byte,
    input wire logic        line_tx_ccs,
    input wire logic        bp_out_req,
    input wire logic        data_out_en,
    input wire logic        control_out_en,
    input wire logic        cas_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase still waiting
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // request taken by an empty buffer
    sequence s_push_empty;
        line_tx_req && line_tx_req_ready && !line_tx_valid;
    endsequence
    a_ready_answers: assert property (s_access |=> pready)
        else $error("no answer after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_zero_data: assert property (pslverr |-> pready && prdata == 0)
        else $error("error without ready or with data");
    a_push_shows: assert property (s_push_empty |=> line_tx_valid)
        else $error("pushed entry not shown");
    a_head_holds: assert property (line_tx_valid && !line_tx_ready |=>
        line_tx_valid && $stable(line_tx_byte) && $stable(line_tx_slot))
        else $error("head changed while stalled");
    a_ccs_slots: assert property (line_tx_valid && line_tx_ccs |->
        line_tx_slot inside {5'h0F, 5'h10, 5'h1F})
        else $error("ccs flag on other slot");
    a_cas_no_ccs: assert property (s_push_empty ##0 cas_mode |=>
        !line_tx_ccs)
        else $error("ccs fill in cas mode");
    a_ccs_fills: assert property (s_push_empty ##0 !cas_mode ##0
        line_tx_req_slot inside {5'h0F, 5'h10, 5'h1F} |=>
        line_tx_ccs && line_tx_slot == $past(line_tx_req_slot))
        else $error("ccs slot not filled");
    a_out_needs_req: assert property (!bp_out_req |=>
        !data_out_en && !control_out_en)
        else $error("output without request");
endmodule
`default_nettype wire

//--- verif/ecr_bp_model.sv
// backplane partner: walks every channel once per frame
`timescale 1ns/100ps
`default_nettype none
module ecr_bp_model
(
    input  wire logic       pclk,        // shared clock
    input  wire logic       presetn,     // async reset, active low
    input  wire logic       go,          // start one frame
    input  wire logic       rate8,       // 128 channels when set
    output logic            bp_in_valid, // channel strobe
    output logic      [6:0] bp_in_chan,  // channel index
    output logic      [7:0] data_byte,   // data input stream byte
    output logic      [7:0] ctrl_byte    // control input stream byte
);
    logic [6:0] cnt_q; // next channel
    logic       run_q; // frame in progress
    logic [6:0] last;  // final channel of a frame
    assign last = rate8 ? 7'h7F : 7'h1F;
    // one channel a cycle; idle lines invert so stale bytes never match
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {run_q, cnt_q, bp_in_valid, bp_in_chan} <= '0;
            {data_byte, ctrl_byte} <= '0;
        end
        else if (run_q)
        begin
            bp_in_valid <= 1'b1;
            bp_in_chan  <= cnt_q;
            data_byte   <= {1'b0, cnt_q} + 8'h11;
            ctrl_byte   <= ~{1'b0, cnt_q};
            cnt_q       <= cnt_q + 7'h01;
            run_q       <= cnt_q != last;
        end
        else
        begin
            bp_in_valid <= 1'b0;
            bp_in_chan  <= ~bp_in_chan;
            data_byte   <= ~data_byte;
            ctrl_byte   <= ~ctrl_byte;
            cnt_q       <= '0;
            run_q       <= go;
        end
    end
endmodule
`default_nettype wire

//--- verif/ecr_router_tb.sv
// self-checking bench for the ccs timeslot router
`timescale 1ns/100ps
`default_nettype none
module ecr_router_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  bp_in_chan, bp_out_chan;
    logic [7:0]  din, cin, tx_byte, rx_byte, dout, cout;
    logic [4:0]  req_slot, tx_slot, rx_slot;
    logic        bp_in_valid, go, rate8, tx_req, req_rdy, tx_valid, tx_rdy;
    logic        tx_ccs, rx_valid, out_req, dout_en, cout_en, cas;
    int          mismatches, checks_done;
    ecr_bp_model u_ecr_bp_model (.pclk(pclk), .presetn(presetn), .go(go),
        .rate8(rate8), .bp_in_valid(bp_in_valid), .bp_in_chan(bp_in_chan),
        .data_byte(din), .ctrl_byte(cin));
    ecr_router u_ecr_router (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bp_in_valid(bp_in_valid), .bp_in_chan(bp_in_chan),
        .data_stream_in(din), .control_stream_in(cin),
        .line_tx_req(tx_req), .line_tx_req_slot(req_slot),
        .line_tx_req_ready(req_rdy), .line_tx_valid(tx_valid),
        .line_tx_ready(tx_rdy), .line_tx_slot(tx_slot),
        .line_tx_byte(tx_byte), .line_tx_ccs(tx_ccs),
        .line_rx_valid(rx_valid), .line_rx_slot(rx_slot),
        .line_rx_byte(rx_byte), .bp_out_req(out_req),
        .bp_out_chan(bp_out_chan), .data_out_en(dout_en),
        .data_stream_out(dout), .control_out_en(cout_en),
        .control_stream_out(cout), .cas_mode(cas));
    // free-running 250 MHz clock
    always #2 pclk = ~pclk;
    // partner byte patterns per channel
    function automatic logic [7:0] db(input logic [6:0] c);
        return {1'b0, c} + 8'h11;
    endfunction
    function automatic logic [7:0] cb(input logic [6:0] c);
        return ~{1'b0, c};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // partner sends one whole frame
    task automatic frame(input logic r8);
        int n;
        n = 0;
        @(posedge pclk);
        {rate8, go} <= {r8, 1'b1};
        @(posedge pclk);
        go <= 1'b0;
        do @(posedge pclk); while (n++ < 3 || bp_in_valid);
    endtask
    task automatic push(input logic [4:0] s);
        @(posedge pclk);
        {tx_req, req_slot} <= {1'b1, s};
        do @(posedge pclk); while (req_rdy !== 1'b1);
        tx_req <= 1'b0;
    endtask
    task automatic pop(input logic [4:0] s, input logic [7:0] b,
                       input logic c);
        @(posedge pclk);
        tx_rdy <= 1'b1;
        do @(posedge pclk); while (tx_valid !== 1'b1);
        chk(32'({tx_ccs, tx_slot, tx_byte}), 32'({c, s, b}));
        tx_rdy <= 1'b0;
    endtask
    task automatic out(input logic [6:0] c, input logic de, input logic ce,
                       input logic [7:0] b);
        @(posedge pclk);
        {out_req, bp_out_chan} <= {1'b1, c};
        @(posedge pclk);
        out_req <= 1'b0;
        @(posedge pclk);
        chk(32'({dout_en, cout_en}), 32'({de, ce}));
        chk(32'({de ? dout : b, ce ? cout : b}), 32'({b, b}));
    endtask
    // watchdog cuts a hang short
    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        close_out();
    end
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {go, rate8, tx_req, req_slot, tx_rdy, out_req, bp_out_chan} = '0;
        {rx_valid, rx_slot, rx_byte} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        chk(32'(cas), 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("test reset done");
        frame(1'b0);
        push(5'h10);
        pop(5'h10, 8'h00, 1'b0);
        $display("test cas done");
        apb(1'b1, 12'h000, 32'h1);
        frame(1'b0);
        push(5'h0F);
        push(5'h10);
        @(posedge pclk);
        chk(32'(req_rdy), 32'h0);
        pop(5'h0F, db(7'd15), 1'b1);
        push(5'h1F);
        pop(5'h10, db(7'd16), 1'b1);
        pop(5'h1F, db(7'd31), 1'b1);
        $display("test data source done");
        apb(1'b1, 12'h000, 32'hB);
        apb(1'b1, 12'h004, 32'hFF09_E305);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1F09_0305);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0000_0045);
        frame(1'b1);
        push(5'h0F);
        pop(5'h0F, cb(7'd14), 1'b1);
        push(5'h10);
        pop(5'h10, db(7'd66), 1'b1);
        push(5'h1F);
        pop(5'h1F, cb(7'd126), 1'b1);
        chk(32'(cas), 32'h0);
        $display("test side source done");
        rx(5'h0F, 8'hA1);
        rx(5'h10, 8'hB2);
        rx(5'h1F, 8'hC3);
        out(7'd62, 1'b1, 1'b0, 8'hA1);
        out(7'd14, 1'b0, 1'b1, 8'hA1);
        out(7'd38, 1'b0, 1'b0, 8'hB2);
        out(7'd66, 1'b1, 1'b0, 8'hB2);
        out(7'd126, 1'b1, 1'b1, 8'hC3);
        $display("test receive done");
        close_out();
    end
    task automatic rx(input logic [4:0] s, input logic [7:0] b);
        @(posedge pclk);
        {rx_valid, rx_slot, rx_byte} <= {1'b1, s, b};
        @(posedge pclk);
        rx_valid <= 1'b0;
    endtask
endmodule
bind ecr_router ecr_router_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_tx_req(line_tx_req),
    .line_tx_req_slot(line_tx_req_slot),
    .line_tx_req_ready(line_tx_req_ready), .line_tx_valid(line_tx_valid),
    .line_tx_ready(line_tx_ready), .line_tx_slot(line_tx_slot),
    .line_tx_byte(line_tx_byte), .line_tx_ccs(line_tx_ccs),
    .bp_out_req(bp_out_req), .data_out_en(data_out_en),
    .control_out_en(control_out_en), .cas_mode(cas_mode));
`default_nettype wire
